// ---- src/lvdc_top.sv ----
// lvdc_top: control/status register of the low-voltage detector
// assumes: cpu byte or bit writes on the system clock, comparator outputs async
//
// Summary of operation
// - generic reset loads register with 00H
// - flag bit0, action bit1, source bit2
// - detector on bit at bit 7
// - on bit 0 disables, 1 enables detection
// - source 0 supply rail, 1 external pin
// - action 0: interrupt on either crossing
// - action 1: reset held while below threshold
// - flag reads below, zero when disabled
// - detector reset keeps on/source/action bits
// - other resets load 82H or 00H by option
// - accepts single-bit and full byte writes
// - flag may glitch while comparator settles
// - disabling while low may raise interrupt
`timescale 1ns/10ps
module lvdc_top (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic RESET_BY_DETECTOR,
   input wire logic DEFAULT_OFF_OPTION,
   input wire logic [19:0] ADDR,
   input wire logic WR_BYTE,
   input wire logic WR_BIT,
   input wire logic [2:0] BIT_SEL,
   input wire logic [7:0] WDATA,
   input wire logic RD,
   input wire logic CMP_SUPPLY_BELOW,
   input wire logic CMP_EXTERNAL_BELOW,
   output logic [7:0] RDATA,
   output logic DETECTOR_INTERRUPT,
   output logic DETECTOR_RESET_REQ,
   output logic DETECTOR_ON,
   output logic SOURCE_SELECT
);
   // ----------------------------------------------------------------
   // synchronised comparator inputs
   // ----------------------------------------------------------------
   logic supply_below_s;
   logic external_below_s;

   lvdc_sync2 u_sync_supply (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .d_async(CMP_SUPPLY_BELOW),
      .q(supply_below_s)
   );

   lvdc_sync2 u_sync_external (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .d_async(CMP_EXTERNAL_BELOW),
      .q(external_below_s)
   );

   // ----------------------------------------------------------------
   // control bits
   // ----------------------------------------------------------------
   logic on_reg;
   logic on_next;
   logic source_reg;
   logic source_next;
   logic action_reg;
   logic action_next;
   logic started_reg;
   // retention copies, written in the always-on block further down
   logic keep_on_reg;
   logic keep_src_reg;
   logic keep_act_reg;

   wire addr_hit = (ADDR == lvdc_pkg::LVDC_CTRL_ADDR);
   wire byte_wr = addr_hit & WR_BYTE;
   wire bit_wr = addr_hit & WR_BIT & ~WR_BYTE;
   wire bit_val = WDATA[BIT_SEL];
   wire hit_on = bit_wr & (BIT_SEL == 3'(lvdc_pkg::LVDC_BIT_ON));
   wire hit_src = bit_wr & (BIT_SEL == 3'(lvdc_pkg::LVDC_BIT_SOURCE));
   wire hit_act = bit_wr & (BIT_SEL == 3'(lvdc_pkg::LVDC_BIT_ACTION));
   // bit 0 and bits 3..6 are never written

   assign on_next = byte_wr ? WDATA[lvdc_pkg::LVDC_BIT_ON] :
                    hit_on ? bit_val : on_reg;
   assign source_next = byte_wr ? WDATA[lvdc_pkg::LVDC_BIT_SOURCE] :
                        hit_src ? bit_val : source_reg;
   assign action_next = byte_wr ? WDATA[lvdc_pkg::LVDC_BIT_ACTION] :
                        hit_act ? bit_val : action_reg;

   // asynchronous reset gives 00H; reset-source values load on the
   // first clocked edge after release
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         on_reg <= lvdc_pkg::LVDC_RST_GENERIC[lvdc_pkg::LVDC_BIT_ON];
         source_reg <= lvdc_pkg::LVDC_RST_GENERIC[lvdc_pkg::LVDC_BIT_SOURCE];
         action_reg <= lvdc_pkg::LVDC_RST_GENERIC[lvdc_pkg::LVDC_BIT_ACTION];
         started_reg <= 1'b0;
      end else if (!started_reg) begin
         started_reg <= 1'b1;
         if (!RESET_BY_DETECTOR) begin
            on_reg <= DEFAULT_OFF_OPTION ?
               lvdc_pkg::LVDC_RST_DEFAULT_OFF[lvdc_pkg::LVDC_BIT_ON] :
               lvdc_pkg::LVDC_RST_DEFAULT_ON[lvdc_pkg::LVDC_BIT_ON];
            source_reg <= 1'b0;
            action_reg <= DEFAULT_OFF_OPTION ?
               lvdc_pkg::LVDC_RST_DEFAULT_OFF[lvdc_pkg::LVDC_BIT_ACTION] :
               lvdc_pkg::LVDC_RST_DEFAULT_ON[lvdc_pkg::LVDC_BIT_ACTION];
         end
         // detector reset: retained copies are restored below
         else begin
            on_reg <= keep_on_reg;
            source_reg <= keep_src_reg;
            action_reg <= keep_act_reg;
         end
      end else begin
         on_reg <= on_next;
         source_reg <= source_next;
         action_reg <= action_next;
      end
   end

   // ----------------------------------------------------------------
   // retention copies, on an always-on domain (no RESETN)
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RESETN && started_reg) begin
         keep_on_reg <= on_next;
         keep_src_reg <= source_next;
         keep_act_reg <= action_next;
      end
   end

   // ----------------------------------------------------------------
   // monitored input, flag, interrupt and reset request
   // ----------------------------------------------------------------
   wire below_sel = source_reg ? external_below_s : supply_below_s;
   // comparator runs only while enabled; settling glitches pass through
   wire below_live = on_reg & below_sel;
   logic crossing;

   // turning the detector off while low is seen as a crossing
   lvdc_edge u_edge (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .en(~action_reg),
      .d(below_live),
      .pulse(crossing)
   );

   logic flag_reg;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         flag_reg <= 1'b0;
         DETECTOR_RESET_REQ <= 1'b0;
      end else begin
         flag_reg <= below_live;
         DETECTOR_RESET_REQ <= action_reg & below_live;
      end
   end

   assign DETECTOR_INTERRUPT = crossing;

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   // flag is gated by the live on bit so it reads zero as soon as detection stops
   wire flag_rd = flag_reg & on_reg;
   wire [7:0] rd_word = {on_reg, 4'h0, source_reg, action_reg, flag_rd};
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
         DETECTOR_ON <= 1'b0;
         SOURCE_SELECT <= 1'b0;
      end else begin
         RDATA <= (RD & addr_hit) ? rd_word : 8'h00;
         DETECTOR_ON <= on_reg;
         SOURCE_SELECT <= source_reg;
      end
   end
endmodule : lvdc_top

// ---- shared/lvdc_pkg.sv ----
// lvdc_pkg: constants for the low-voltage detect control register block
// assumes: single system clock, cpu register port at one byte address
package lvdc_pkg;
   localparam logic [19:0] LVDC_CTRL_ADDR = 20'hfffa9;
   localparam int LVDC_BIT_FLAG = 0;
   localparam int LVDC_BIT_ACTION = 1;
   localparam int LVDC_BIT_SOURCE = 2;
   localparam int LVDC_BIT_ON = 7;
   localparam logic [7:0] LVDC_RST_GENERIC = 8'h00;
   localparam logic [7:0] LVDC_RST_DEFAULT_ON = 8'h82;
   localparam logic [7:0] LVDC_RST_DEFAULT_OFF = 8'h00;
   // writable bit positions: on, source, action
   localparam logic [7:0] LVDC_WR_MASK = 8'h86;
   localparam logic [2:0] LVDC_BITSEL_MAX = 3'h7;
endpackage : lvdc_pkg

// ---- src/lvdc_sync2.sv ----
// lvdc_sync2: two-flop synchroniser for one level
// assumes: input asynchronous to clk
`timescale 1ns/10ps
module lvdc_sync2 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d_async,
   output logic q
);
   logic meta_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d_async;
         q <= meta_reg;
      end
   end
endmodule : lvdc_sync2

// ---- src/lvdc_edge.sv ----
// lvdc_edge: any-edge detector with enable, one-cycle pulse out
// assumes: input already synchronous
`timescale 1ns/10ps
module lvdc_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic d,
   output logic pulse
);
   logic prev_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= 1'b0;
         pulse <= 1'b0;
      end else begin
         prev_reg <= d;
         pulse <= en & (d ^ prev_reg);
      end
   end
endmodule : lvdc_edge

// ---- tb/lvdc_sva.sv ----
// lvdc_sva: port-level checks of the low-voltage detect control block
// assumes: bound to lvdc_top, single clock domain
`timescale 1ns/10ps
module lvdc_sva (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic [19:0] ADDR,
   input wire logic WR_BYTE,
   input wire logic WR_BIT,
   input wire logic [7:0] WDATA,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic DETECTOR_INTERRUPT,
   input wire logic DETECTOR_ON,
   input wire logic SOURCE_SELECT
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   wire hit = ADDR == lvdc_pkg::LVDC_CTRL_ADDR;
   sequence byte_wr_s;
      WR_BYTE && hit ##1 !(WR_BYTE || WR_BIT);
   endsequence
   irq_pulse_a: assert property (DETECTOR_INTERRUPT |=> !DETECTOR_INTERRUPT)
      else $error("interrupt longer than one cycle");
   on_write_a: assert property (byte_wr_s |=> DETECTOR_ON == $past(WDATA[7], 2))
      else $error("on bit not taken from byte write");
   src_write_a: assert property (byte_wr_s |=> SOURCE_SELECT == $past(WDATA[2], 2))
      else $error("source bit not taken from byte write");
   rd_idle_a: assert property (!(RD && hit) |=> RDATA == 8'h00)
      else $error("read data without a read");
   rd_pad_a: assert property (RDATA[6:3] == 4'h0)
      else $error("unused bits read nonzero");
   rd_copy_a: assert property (RD && hit |=> RDATA[7] == DETECTOR_ON && RDATA[2] == SOURCE_SELECT)
      else $error("read data disagrees with control copies");
   flag_gate_a: assert property (RDATA[0] |-> RDATA[7])
      else $error("flag set while detector off");
   quiet_off_a: assert property ((!DETECTOR_ON)[*4] |-> !DETECTOR_INTERRUPT)
      else $error("interrupt while detector off");
endmodule : lvdc_sva

// ---- tb/lvdc_tb_top.sv ----
// low_voltage_detect_control_tb_top: directed bench for lvdc_top
// assumes: lvdc_pkg compiled first, checker bound below
`timescale 1ns/10ps
module low_voltage_detect_control_tb_top;
   logic CLK_SYS = 0, RESETN = 0, RESET_BY_DETECTOR = 0, DEFAULT_OFF_OPTION = 0;
   logic [19:0] ADDR = lvdc_pkg::LVDC_CTRL_ADDR;
   logic WR_BYTE = 0, WR_BIT = 0, RD = 0, CMP_SUPPLY_BELOW = 0, CMP_EXTERNAL_BELOW = 0;
   logic [2:0] BIT_SEL = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic [7:0] RDATA;
   logic DETECTOR_INTERRUPT, DETECTOR_RESET_REQ, DETECTOR_ON, SOURCE_SELECT;
   int err_total = 0, check_count = 0, irqs = 0;
   lvdc_top dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .RESET_BY_DETECTOR(RESET_BY_DETECTOR),
      .DEFAULT_OFF_OPTION(DEFAULT_OFF_OPTION), .ADDR(ADDR), .WR_BYTE(WR_BYTE), .WR_BIT(WR_BIT),
      .BIT_SEL(BIT_SEL), .WDATA(WDATA), .RD(RD), .CMP_SUPPLY_BELOW(CMP_SUPPLY_BELOW),
      .CMP_EXTERNAL_BELOW(CMP_EXTERNAL_BELOW), .RDATA(RDATA),
      .DETECTOR_INTERRUPT(DETECTOR_INTERRUPT), .DETECTOR_RESET_REQ(DETECTOR_RESET_REQ),
      .DETECTOR_ON(DETECTOR_ON), .SOURCE_SELECT(SOURCE_SELECT));
   initial forever #5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) if (DETECTOR_INTERRUPT === 1'b1) irqs++;
   // --------------------------------------------------------------
   // bus and check tasks
   // --------------------------------------------------------------
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task rst(input logic det, input logic opt);
      @(posedge CLK_SYS) RESETN <= 0;
      RESET_BY_DETECTOR <= det;
      DEFAULT_OFF_OPTION <= opt;
      repeat (12) @(posedge CLK_SYS);
      RESETN <= 1;
      repeat (2) @(posedge CLK_SYS);
   endtask : rst
   task wr(input logic b, input logic [2:0] sel, input logic [7:0] d);
      @(posedge CLK_SYS) WR_BYTE <= b;
      WR_BIT <= !b;
      BIT_SEL <= sel;
      WDATA <= d;
      @(posedge CLK_SYS) WR_BYTE <= 0;
      WR_BIT <= 0;
   endtask : wr
   task rd(input logic [19:0] a, input logic [7:0] e);
      @(posedge CLK_SYS) RD <= 1;
      ADDR <= a;
      @(posedge CLK_SYS) RD <= 0;
      ADDR <= lvdc_pkg::LVDC_CTRL_ADDR;
      #1 chk("ctrl", RDATA, e);
   endtask : rd
   task cmp(input logic s, input logic x);
      @(posedge CLK_SYS) CMP_SUPPLY_BELOW <= s;
      CMP_EXTERNAL_BELOW <= x;
      repeat (8) @(posedge CLK_SYS);
   endtask : cmp
   task t_regs();
      wr(1, 0, 8'hff);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h86);
      wr(0, 7, 8'h00);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h06);
      rd(20'hfffaa, 8'h00);
      $display("regs done");
   endtask : t_regs
   task t_irq();
      wr(1, 0, 8'h80);
      repeat (21000) @(posedge CLK_SYS);
      cmp(1, 0);
      chk("irq fall", 8'(irqs), 8'h01);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h81);
      cmp(0, 0);
      chk("irq rise", 8'(irqs), 8'h02);
      wr(1, 0, 8'h84);
      cmp(1, 0);
      chk("irq other", 8'(irqs), 8'h02);
      cmp(1, 1);
      chk("irq ext", 8'(irqs), 8'h03);
      wr(0, 7, 8'h00);
      repeat (6) @(posedge CLK_SYS);
      chk("irq off", 8'(irqs), 8'h04);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h04);
      cmp(0, 0);
      $display("irq done");
   endtask : t_irq
   task t_rreq();
      wr(1, 0, 8'h82);
      cmp(1, 0);
      chk("rreq on", 8'(DETECTOR_RESET_REQ), 8'h01);
      cmp(0, 0);
      chk("rreq off", 8'(DETECTOR_RESET_REQ), 8'h00);
      wr(1, 0, 8'h84);
      rst(1, 1);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h84);
      rst(0, 1);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, lvdc_pkg::LVDC_RST_GENERIC);
      rst(0, 0);
      rd(lvdc_pkg::LVDC_CTRL_ADDR, 8'h82);
      $display("reset done");
   endtask : t_rreq
   task final_report();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      rst(0, 1);
      t_regs();
      t_irq();
      t_rreq();
      final_report();
   end
endmodule : low_voltage_detect_control_tb_top
bind lvdc_top lvdc_sva u_sva (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR),
   .WR_BYTE(WR_BYTE), .WR_BIT(WR_BIT), .WDATA(WDATA), .RD(RD), .RDATA(RDATA),
   .DETECTOR_INTERRUPT(DETECTOR_INTERRUPT), .DETECTOR_ON(DETECTOR_ON),
   .SOURCE_SELECT(SOURCE_SELECT));
